/* File: hdl/pfmux_pkg.sv */
// Purpose: Shared constants and types for the pad function mux block
// Assumes: 32-bit register words on a plain strobe port
// Notes:   Register offsets are byte addresses, one aligned word each
package pfmux_pkg;

    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SEL_W  = 3;

    // Register offsets
    localparam logic [7:0] OFS_SEL_B  = 8'h00;
    localparam logic [7:0] OFS_SEL_C  = 8'h04;
    localparam logic [7:0] OFS_SEL_D  = 8'h08;
    localparam logic [7:0] OFS_PULL_0 = 8'h0c;
    localparam logic [7:0] OFS_PULL_1 = 8'h10;

    // Select field positions (lsb of each three-bit field)
    localparam int B_CLKREQ_LSB = 18;
    localparam int B_SYNC_LSB   = 12;
    localparam int B_DOUT_LSB   = 9;
    localparam int B_DIN_LSB    = 6;
    localparam int B_CLK_LSB    = 3;
    localparam int C_TX_LSB     = 27;
    localparam int C_RTS_LSB    = 24;
    localparam int C_CTS_LSB    = 21;
    localparam int C_RX_LSB     = 18;
    localparam int C_BDOUT_LSB  = 15;
    localparam int C_BFSR_LSB   = 12;
    localparam int C_BCLKR_LSB  = 6;
    localparam int C_BDIN_LSB   = 0;
    localparam int D_DAT3_LSB   = 12;
    localparam int D_NCS2_LSB   = 6;

    // Pulldown bit positions
    localparam int P0_CAM_HS  = 28;
    localparam int P0_CAM_D2  = 24;
    localparam int P0_CAM_D3  = 23;
    localparam int P0_CAM_D5  = 21;
    localparam int P0_BSP1_DI = 16;
    localparam int P1_BSP3_CK = 29;
    localparam int P1_BOOT    = 27;
    localparam int P1_EMU1    = 26;
    localparam int P1_EMU0    = 25;
    localparam int P1_UW_SDI  = 18;
    localparam int P1_IO2     = 14;
    localparam int P1_IO4     = 13;

    // Implemented bits, compatibility-forced bits and forced values
    localparam logic [31:0] MASK_B     = 32'h001c7ff8;
    localparam logic [31:0] MASK_C     = 32'h3ffff1c7;
    localparam logic [31:0] MASK_D     = 32'h000071c0;
    localparam logic [31:0] MASK_P0    = 32'h11a10000;
    localparam logic [31:0] MASK_P1    = 32'h2e046000;
    localparam logic [31:0] CMP_MASK_D = 32'h00000000;
    localparam logic [31:0] FORCE_SEL  = 32'h00000000;
    localparam logic [31:0] FORCE_P0   = 32'h11a10000;
    localparam logic [31:0] FORCE_P1   = 32'h26040000;
    localparam logic [31:0] WORD_RST   = 32'h00000000;

    // Per-pad function selections
    typedef struct packed {
        logic [2:0] uartTwoClockRequestSel;
        logic [2:0] serialIfTwoSyncSel;
        logic [2:0] serialIfTwoDataoutSel;
        logic [2:0] serialIfTwoDatainSel;
        logic [2:0] serialIfTwoClockSel;
        logic [2:0] uartTwoTransmitSel;
        logic [2:0] uartTwoRequestSendSel;
        logic [2:0] uartTwoClearSendSel;
        logic [2:0] uartTwoReceiveSel;
        logic [2:0] bspTwoDataoutSel;
        logic [2:0] bspTwoRxFrameSel;
        logic [2:0] bspTwoRxClockSel;
        logic [2:0] bspTwoDatainSel;
        logic [2:0] cardDataThreeSel;
        logic [2:0] flashChipSelectTwoSel;
    } pfmux_sel_t;

    // Per-pad pulldown, one bit each
    typedef struct packed {
        logic cameraHsyncPullLow;
        logic cameraData2PullLow;
        logic cameraData3PullLow;
        logic cameraData5PullLow;
        logic bspOneDatainPullLow;
        logic bspThreeClockPullLow;
        logic bootSelectPullLow;
        logic emulationOnePullLow;
        logic emulationZeroPullLow;
        logic microwireDatainPullLow;
        logic cpuIoTwoPullLow;
        logic cpuIoFourPullLow;
    } pfmux_pull_t;

    // Boot and both cpu io pads engaged at reset
    localparam pfmux_pull_t PULL_ON_RST = 12'h023;
    localparam pfmux_sel_t  SEL_RST     = '0;

endpackage

/* File: hdl/pfmux_pad_ctrl.sv */
// Behaviour
// RQ1: Select fields are three bits, zero at reset and, except register D, in compatibility mode.
// RQ2: Register B holds clock request and serial interface two selects.
// RQ3: Register C holds second UART transmit, rts, cts, receive selects.
// RQ4: Register C holds second serial port data, sync, clock selects.
// RQ5: Register D card data3 and flash cs2 selects zeroed only by reset.
// RQ6: Software writes zero to every reserved bit.
// RQ7: Pulldown bit zero engages pulldown, one releases it.
// RQ8: Pulldowns default off in compatibility mode unless an exception.
// RQ9: Register pulldown bits act only in native mode.
// RQ10: Boot, cpu io two and four pulldowns forced on in compatibility.
// RQ11: Pulldown word 0 holds camera and first serial port bits.
// RQ12: Pulldown word 1 holds serial clock, emulation, microwire bits.
// RQ13: A pad with no pulldown in its function ignores its bit.
// RQ14: Fields read back last write, or forced value while forced.
//
// Purpose: Pad function select and pulldown control registers
// Assumes: Register port strobes are one cycle, never both at once
// Notes:   Pad outputs lag register state by one clock
`timescale 1ns/10ps
module pfmux_pad_ctrl (
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    // Register port
    input  wire logic [pfmux_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [pfmux_pkg::DATA_W-1:0] regWdata,
    input  wire logic                       regWr,
    input  wire logic                       regRd,
    output logic      [pfmux_pkg::DATA_W-1:0] regRdata,
    // Mode and pad capability
    input  wire logic                       compatMode,
    input  wire pfmux_pkg::pfmux_pull_t     pullAvail,
    // Pad controls
    output pfmux_pkg::pfmux_sel_t           padSel,
    output pfmux_pkg::pfmux_pull_t          pullOn
);
    import pfmux_pkg::*;

    // Stored words, reserved bits never kept
    logic [31:0] selB_r;
    logic [31:0] selC_r;
    logic [31:0] selD_r;
    logic [31:0] pull0_r;
    logic [31:0] pull1_r;
    logic [31:0] regRdata_r;
    logic [31:0] regRdata_nxt;
    pfmux_sel_t  padSel_r;
    pfmux_sel_t  padSel_nxt;
    pfmux_pull_t pullOn_r;
    pfmux_pull_t pullOn_nxt;

    // Word as seen by pads and reads, with forced bits applied
    function automatic logic [31:0] eff_word(
        input logic [31:0] stored,
        input logic [31:0] cmpMask,
        input logic [31:0] forceVal,
        input logic        cmp
    );
        eff_word = cmp ? ((stored & ~cmpMask) | (forceVal & cmpMask))
                       : stored;
    endfunction

    // Three-bit field extraction
    function automatic logic [2:0] fld(
        input logic [31:0] w,
        input int          lsb
    );
        fld = w[lsb +: SEL_W];
    endfunction

    // Address decode
    wire hitB  = (regAddr == OFS_SEL_B);
    wire hitC  = (regAddr == OFS_SEL_C);
    wire hitD  = (regAddr == OFS_SEL_D);
    wire hitP0 = (regAddr == OFS_PULL_0);
    wire hitP1 = (regAddr == OFS_PULL_1);

    // Effective words; register D is not held by compatibility mode
    wire [31:0] effB  = eff_word(selB_r, MASK_B, FORCE_SEL,
                                 compatMode); // RQ1
    wire [31:0] effC  = eff_word(selC_r, MASK_C, FORCE_SEL,
                                 compatMode); // RQ1
    wire [31:0] effD  = eff_word(selD_r, CMP_MASK_D, FORCE_SEL,
                                 compatMode); // RQ5
    wire [31:0] effP0 = eff_word(pull0_r, MASK_P0, FORCE_P0,
                                 compatMode); // RQ8
    wire [31:0] effP1 = eff_word(pull1_r, MASK_P1, FORCE_P1,
                                 compatMode); // RQ10

    // Read mux; unmapped addresses return zero
    wire [31:0] rdSel = hitB  ? effB  :
                        hitC  ? effC  :
                        hitD  ? effD  :
                        hitP0 ? effP0 :
                        hitP1 ? effP1 : 32'h00000000; // RQ14
    assign regRdata_nxt = regRd ? rdSel : 32'h00000000;

    // Select fields laid out per register
    assign padSel_nxt = '{
        uartTwoClockRequestSel: fld(effB, B_CLKREQ_LSB), // RQ2
        serialIfTwoSyncSel:     fld(effB, B_SYNC_LSB),
        serialIfTwoDataoutSel:  fld(effB, B_DOUT_LSB),
        serialIfTwoDatainSel:   fld(effB, B_DIN_LSB),
        serialIfTwoClockSel:    fld(effB, B_CLK_LSB),
        uartTwoTransmitSel:     fld(effC, C_TX_LSB), // RQ3
        uartTwoRequestSendSel:  fld(effC, C_RTS_LSB),
        uartTwoClearSendSel:    fld(effC, C_CTS_LSB),
        uartTwoReceiveSel:      fld(effC, C_RX_LSB),
        bspTwoDataoutSel:       fld(effC, C_BDOUT_LSB), // RQ4
        bspTwoRxFrameSel:       fld(effC, C_BFSR_LSB),
        bspTwoRxClockSel:       fld(effC, C_BCLKR_LSB),
        bspTwoDatainSel:        fld(effC, C_BDIN_LSB),
        cardDataThreeSel:       fld(effD, D_DAT3_LSB), // RQ5
        flashChipSelectTwoSel:  fld(effD, D_NCS2_LSB)
    };

    // Zero bit engages; pads lacking a pulldown stay released
    wire pfmux_pull_t pullWant = '{
        cameraHsyncPullLow:     ~effP0[P0_CAM_HS], // RQ11
        cameraData2PullLow:     ~effP0[P0_CAM_D2],
        cameraData3PullLow:     ~effP0[P0_CAM_D3],
        cameraData5PullLow:     ~effP0[P0_CAM_D5],
        bspOneDatainPullLow:    ~effP0[P0_BSP1_DI],
        bspThreeClockPullLow:   ~effP1[P1_BSP3_CK], // RQ12
        bootSelectPullLow:      ~effP1[P1_BOOT],
        emulationOnePullLow:    ~effP1[P1_EMU1],
        emulationZeroPullLow:   ~effP1[P1_EMU0],
        microwireDatainPullLow: ~effP1[P1_UW_SDI],
        cpuIoTwoPullLow:        ~effP1[P1_IO2],
        cpuIoFourPullLow:       ~effP1[P1_IO4]
    }; // RQ7 RQ9
    assign pullOn_nxt = pfmux_pull_t'(pullWant & pullAvail); // RQ13

    // Register writes; reserved bits dropped so they read zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            selB_r  <= WORD_RST; // RQ1
            selC_r  <= WORD_RST;
            selD_r  <= WORD_RST;
            pull0_r <= WORD_RST;
            pull1_r <= WORD_RST;
        end else if (regWr) begin
            if (hitB)  selB_r  <= regWdata & MASK_B; // RQ6
            if (hitC)  selC_r  <= regWdata & MASK_C;
            if (hitD)  selD_r  <= regWdata & MASK_D;
            if (hitP0) pull0_r <= regWdata & MASK_P0;
            if (hitP1) pull1_r <= regWdata & MASK_P1;
        end
    end

    // Output flops keep pad controls glitch free
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            padSel_r   <= SEL_RST;
            pullOn_r   <= PULL_ON_RST; // RQ10
            regRdata_r <= 32'h00000000;
        end else begin
            padSel_r   <= padSel_nxt;
            pullOn_r   <= pullOn_nxt;
            regRdata_r <= regRdata_nxt;
        end
    end

    assign padSel   = padSel_r;
    assign pullOn   = pullOn_r;
    assign regRdata = regRdata_r;

    // Checks on the driven pad and read state
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_native_wr(logic [7:0] ofs);
        regWr && regAddr == ofs && !compatMode ##1 !compatMode;
    endsequence

    sequence s_any_wr(logic [7:0] ofs);
        regWr && regAddr == ofs ##1 1'b1;
    endsequence

    property p_sel_compat_zero;
        compatMode |=> padSel.uartTwoTransmitSel == 3'h0 &&
                       padSel.serialIfTwoSyncSel == 3'h0 &&
                       padSel.bspTwoDatainSel == 3'h0;
    endproperty
    a_sel_compat_zero: assert property (p_sel_compat_zero) // RQ1
        else $error("select not forced to zero in compatibility mode");

    property p_sel_b_clkreq;
        s_native_wr(OFS_SEL_B) |=> padSel.uartTwoClockRequestSel ==
            $past(regWdata[20:18], 2);
    endproperty
    a_sel_b_clkreq: assert property (p_sel_b_clkreq) // RQ2
        else $error("clock request select does not follow write");

    property p_sel_c_tx;
        s_native_wr(OFS_SEL_C) |=> padSel.uartTwoTransmitSel ==
            $past(regWdata[29:27], 2);
    endproperty
    a_sel_c_tx: assert property (p_sel_c_tx) // RQ3
        else $error("uart transmit select does not follow write");

    property p_sel_c_bdin;
        s_native_wr(OFS_SEL_C) |=> padSel.bspTwoDatainSel ==
            $past(regWdata[2:0], 2);
    endproperty
    a_sel_c_bdin: assert property (p_sel_c_bdin) // RQ4
        else $error("serial port data in select does not follow write");

    property p_sel_d_no_force;
        s_any_wr(OFS_SEL_D) |=> padSel.flashChipSelectTwoSel ==
            $past(regWdata[8:6], 2);
    endproperty
    a_sel_d_no_force: assert property (p_sel_d_no_force) // RQ5
        else $error("flash select forced by compatibility mode");

    property p_pull_native;
        !rst && !compatMode |=> pullOn.cameraHsyncPullLow ==
            (!$past(pull0_r[28]) && $past(pullAvail.cameraHsyncPullLow));
    endproperty
    a_pull_native: assert property (p_pull_native) // RQ7
        else $error("camera pulldown does not match register bit");

    property p_pull_compat_off;
        compatMode |=> !pullOn.emulationOnePullLow &&
                       !pullOn.microwireDatainPullLow &&
                       !pullOn.cameraData5PullLow;
    endproperty
    a_pull_compat_off: assert property (p_pull_compat_off) // RQ8
        else $error("pulldown not released in compatibility mode");

    property p_pull_compat_on;
        compatMode |=> pullOn.bootSelectPullLow ==
                       $past(pullAvail.bootSelectPullLow) &&
                       pullOn.cpuIoFourPullLow ==
                       $past(pullAvail.cpuIoFourPullLow);
    endproperty
    a_pull_compat_on: assert property (p_pull_compat_on) // RQ10
        else $error("boot or cpu io pulldown not engaged");

    property p_pull_unavail;
        !pullAvail.bspOneDatainPullLow |=> !pullOn.bspOneDatainPullLow;
    endproperty
    a_pull_unavail: assert property (p_pull_unavail) // RQ13
        else $error("pulldown engaged on pad without one");

    property p_read_p0;
        regRd && hitP0 && !compatMode |=>
            regRdata == $past(pull0_r);
    endproperty
    a_read_p0: assert property (p_read_p0) // RQ11
        else $error("pulldown word 0 read mismatch");

    property p_read_p1_compat;
        regRd && hitP1 && compatMode |=> regRdata == FORCE_P1;
    endproperty
    a_read_p1_compat: assert property (p_read_p1_compat) // RQ12
        else $error("pulldown word 1 forced read mismatch");

    property p_read_b_compat;
        regRd && hitB && compatMode |=> regRdata == 32'h00000000
            ##1 regRdata == 32'h00000000 || $past(regRd);
    endproperty
    a_read_b_compat: assert property (p_read_b_compat) // RQ14
        else $error("select word B not zero while forced");

    property p_write_readback;
        regWr && hitC ##1 regRd && hitC && !compatMode |=>
            regRdata == ($past(regWdata, 2) & MASK_C);
    endproperty
    a_write_readback: assert property (p_write_readback) // RQ14
        else $error("word C readback differs from last write");

    property p_read_native_pull;
        !rst && !compatMode ##1 !compatMode |->
            pullOn.emulationZeroPullLow ==
            (!$past(pull1_r[25]) && $past(pullAvail.emulationZeroPullLow));
    endproperty
    a_read_native_pull: assert property (p_read_native_pull) // RQ9
        else $error("emulation pulldown ignores native register bit");

    property p_sel_b_sync;
        s_native_wr(OFS_SEL_B) |=> padSel.serialIfTwoSyncSel ==
            $past(regWdata[14:12], 2);
    endproperty
    a_sel_b_sync: assert property (p_sel_b_sync) // RQ2
        else $error("serial interface sync select does not follow write");

    property p_sel_c_rx;
        s_native_wr(OFS_SEL_C) |=> padSel.uartTwoReceiveSel ==
            $past(regWdata[20:18], 2);
    endproperty
    a_sel_c_rx: assert property (p_sel_c_rx) // RQ3
        else $error("uart receive select does not follow write");

    property p_sel_c_bfsr;
        s_native_wr(OFS_SEL_C) |=> padSel.bspTwoRxFrameSel ==
            $past(regWdata[14:12], 2);
    endproperty
    a_sel_c_bfsr: assert property (p_sel_c_bfsr) // RQ4
        else $error("serial port frame select does not follow write");

    // Card and flash selects keep the stored value in compatibility mode
    property p_sel_d_compat_hold;
        compatMode |=> padSel.cardDataThreeSel == $past(selD_r[14:12]) &&
            padSel.flashChipSelectTwoSel == $past(selD_r[8:6]);
    endproperty
    a_sel_d_compat_hold: assert property (p_sel_d_compat_hold) // RQ5
        else $error("card or flash select forced in compatibility mode");

    property p_pull0_bsp_native;
        !rst && !compatMode |=> pullOn.bspOneDatainPullLow ==
            (!$past(pull0_r[16]) && $past(pullAvail.bspOneDatainPullLow));
    endproperty
    a_pull0_bsp_native: assert property (p_pull0_bsp_native) // RQ11
        else $error("serial port data in pulldown does not match bit");

    property p_pull1_wire_native;
        !rst && !compatMode |=> pullOn.microwireDatainPullLow ==
            (!$past(pull1_r[18]) && $past(pullAvail.microwireDatainPullLow));
    endproperty
    a_pull1_wire_native: assert property (p_pull1_wire_native) // RQ12
        else $error("microwire pulldown does not match register bit");

    // Camera hsync, serial port three clock and emulation zero pulldowns, without an exception, stay off when forced
    property p_pull_compat_rest;
        compatMode |=> !pullOn.cameraHsyncPullLow &&
                       !pullOn.bspThreeClockPullLow &&
                       !pullOn.emulationZeroPullLow;
    endproperty
    a_pull_compat_rest: assert property (p_pull_compat_rest) // RQ8
        else $error("pulldown engaged in compatibility mode");

    property p_rdata_idle;
        !regRd |=> regRdata == 32'h00000000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) // RQ14
        else $error("read data not zero outside the answer cycle");

    // Reset values are checked while reset is held, so nothing disables it
    property p_rst_pads;
        disable iff (1'b0)
        rst |=> pullOn == PULL_ON_RST && padSel == SEL_RST;
    endproperty
    a_rst_pads: assert property (p_rst_pads) // RQ10
        else $error("pad controls not at reset values after reset");

    // Unmapped writes must not alias onto any stored word
    property p_unmapped_write;
        regWr && !(hitB || hitC || hitD || hitP0 || hitP1) |=>
            $stable(selB_r) && $stable(selC_r) && $stable(selD_r) &&
            $stable(pull0_r) && $stable(pull1_r);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) // RQ14
        else $error("write to an unmapped address changed a stored word");

endmodule

/* File: dv/pad_function_mux_and_pulldown_ctrl_bench.sv */
// Purpose: Self-checking bench for the pad select and pulldown registers
// Assumes: Register port strobes one cycle, read data in the next cycle
// Notes:   A model of the stored words gives the expected pad and forced read values
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
    mismatches++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module pad_function_mux_and_pulldown_ctrl_bench;
    import pfmux_pkg::*;

    typedef struct {
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] r;
    } pfmux_row_t;

    logic        core_clk;
    logic        rst;
    logic [7:0]  regAddr;
    logic [31:0] regWdata;
    logic        regWr;
    logic        regRd;
    logic [31:0] regRdata;
    logic        compatMode;
    pfmux_pull_t pullAvail;
    pfmux_sel_t  padSel;
    pfmux_pull_t pullOn;
    logic [31:0] m [5];
    logic [31:0] got;
    pfmux_sel_t  eSel;
    pfmux_pull_t ePull;
    int          mismatches;
    int          check_count;

    // Ordinary accesses: address, written word, word read back
    pfmux_row_t rows [17] = '{
        '{8'h00, 32'hffffffff, 32'h001c7ff8},
        '{8'h04, 32'hffffffff, 32'h3ffff1c7},
        '{8'h08, 32'hffffffff, 32'h000071c0},
        '{8'h0c, 32'hffffffff, 32'h11a10000},
        '{8'h10, 32'hffffffff, 32'h2e046000},
        '{8'h00, 32'h000c5ac8, 32'h000c5ac8},
        '{8'h04, 32'h2a5a3145, 32'h2a5a3145},
        '{8'h08, 32'h00005140, 32'h00005140},
        '{8'h0c, 32'h01200000, 32'h01200000},
        '{8'h10, 32'h24004000, 32'h24004000},
        '{8'h00, 32'hffe38007, 32'h00000000},
        '{8'h04, 32'hc0000e38, 32'h00000000},
        '{8'h08, 32'hffff8e3f, 32'h00000000},
        '{8'h0c, 32'hee5effff, 32'h00000000},
        '{8'h10, 32'hd1fb9fff, 32'h00000000},
        '{8'h14, 32'hffffffff, 32'h00000000},
        '{8'hfc, 32'h12345678, 32'h00000000}
    };

    pfmux_pad_ctrl pfmux_pad_ctrl_i (
        .core_clk   (core_clk),
        .rst        (rst),
        .regAddr    (regAddr),
        .regWdata   (regWdata),
        .regWr      (regWr),
        .regRd      (regRd),
        .regRdata   (regRdata),
        .compatMode (compatMode),
        .pullAvail  (pullAvail),
        .padSel     (padSel),
        .pullOn     (pullOn)
    );

    // Free-running core clock, 40 ns period
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Select fields as they should reach the pads
    function automatic pfmux_sel_t expSel(logic [31:0] b, logic [31:0] c,
                                          logic [31:0] d, logic cm);
        if (cm) begin
            b = '0;
            c = '0;
        end
        return {b[20:18], b[14:12], b[11:9], b[8:6], b[5:3], c[29:27],
                c[26:24], c[23:21], c[20:18], c[17:15], c[14:12], c[8:6],
                c[2:0], d[14:12], d[8:6]};
    endfunction

    // Pulldowns: zero bit engages where the pad has one
    function automatic pfmux_pull_t expPull(logic [31:0] p0,
                                            logic [31:0] p1, logic cm,
                                            pfmux_pull_t av);
        pfmux_pull_t b;
        b = {p0[28], p0[24], p0[23], p0[21], p0[16], p1[29], p1[27],
             p1[26], p1[25], p1[18], p1[14], p1[13]};
        return cm ? (12'h023 & av) : (av & ~b);
    endfunction

    // Read-back word, forced values while compatibility applies
    function automatic logic [31:0] expRd(int i, logic cm);
        case (i)
            0, 1:    return cm ? 32'h0 : m[i];
            3:       return cm ? 32'h11a10000 : m[3];
            4:       return cm ? 32'h26040000 : m[4];
            default: return m[i];
        endcase
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask

    // Returns on the edge after the read data cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
        @(posedge core_clk);
    endtask

    // Pad outputs lag the store by a cycle, so sample past the edge
    task automatic chkPads();
        #1;
        eSel = expSel(m[0], m[1], m[2], compatMode);
        ePull = expPull(m[3], m[4], compatMode, pullAvail);
        `CHK("padSel", eSel, padSel)
        `CHK("pullOn", ePull, pullOn)
        @(posedge core_clk);
    endtask

    // Reset held n edges; every word must read zero afterwards
    task automatic doReset(int n);
        rst <= 1'b1;
        repeat (n) @(posedge core_clk);
        `CHK("rstSel", 45'h0, padSel)
        `CHK("rstPull", 12'h023, pullOn)
        `CHK("rstRdata", 32'h0, regRdata)
        rst <= 1'b0;
        m = '{default: 32'h0};
        @(posedge core_clk);
        for (int i = 0; i < 5; i++) begin
            rd(8'(i * 4), got);
            `CHK("rstWord", 32'h0, got)
        end
        chkPads();
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog well past the roughly 140 cycles the run needs
    initial begin
        repeat (5000) @(posedge core_clk);
        mismatches++;
        end_sim();
    end

    initial begin
        int idx;
        rst = 1'b1;
        regAddr = 8'h00;
        regWdata = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        compatMode = 1'b0;
        pullAvail = 12'hfff;
        mismatches = 0;
        check_count = 0;
        doReset(10);
        // Table of writes with read-back, reserved and unmapped included
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, got);
            idx = rows[i].a >> 2;
            if (rows[i].a <= 8'h10) begin
                m[idx] = rows[i].r;
            end
            `CHK("regRdata", rows[i].r, got)
            chkPads();
        end
        // Pads without a pulldown in their function ignore the bit
        wr(OFS_PULL_0, 32'h01200000);
        rd(OFS_PULL_0, got);
        `CHK("pull0", 32'h01200000, got)
        wr(OFS_PULL_1, 32'h24004000);
        rd(OFS_PULL_1, got);
        `CHK("pull1", 32'h24004000, got)
        m[3] = 32'h01200000;
        m[4] = 32'h24004000;
        pullAvail <= 12'h525;
        rd(OFS_SEL_B, got);
        chkPads();
        // Compatibility mode: forced fields, register D untouched
        wr(OFS_SEL_C, 32'h2a5a3145);
        rd(OFS_SEL_C, got);
        `CHK("selC", 32'h2a5a3145, got)
        wr(OFS_SEL_D, 32'h00005140);
        rd(OFS_SEL_D, got);
        `CHK("selD", 32'h00005140, got)
        m[1] = 32'h2a5a3145;
        m[2] = 32'h00005140;
        pullAvail <= 12'hfff;
        compatMode <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(8'(i * 4), got);
            `CHK("cmpWord", expRd(i, 1'b1), got)
        end
        chkPads();
        // Write while forced is kept and shows back in native mode
        wr(OFS_SEL_B, 32'h00041248);
        rd(OFS_SEL_B, got);
        #1;
        `CHK("rdataStands", 32'h0, regRdata)
        `CHK("compatB", 32'h0, got)
        m[0] = 32'h00041248;
        @(posedge core_clk);
        compatMode <= 1'b0;
        rd(OFS_SEL_B, got);
        `CHK("nativeB", 32'h00041248, got)
        chkPads();
        // Reset in mid-run clears the stored words
        doReset(2);
        end_sim();
    end
endmodule
